// File: src/csd_pkg.sv
// Constants, types and helpers shared by the control mode strap decoder
package csd_pkg;

   // ************************************************************
   // Register port geometry
   // ************************************************************
   localparam int ADDR_W = 4;
   localparam int DATA_W = 16;
   localparam int FSADJ_W = 8;
   localparam int COUNT_W = 8;

   // ************************************************************
   // Register offsets
   // ************************************************************
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h0;
   localparam logic [ADDR_W-1:0] ADDR_FSADJ_I = 4'h1;
   localparam logic [ADDR_W-1:0] ADDR_FSADJ_Q = 4'h2;
   localparam logic [ADDR_W-1:0] ADDR_MODE_CHANGES = 4'h3;

   // ************************************************************
   // Status word field positions
   // ************************************************************
   localparam int ST_EXTENDED = 0;
   localparam int ST_DIFFERENTIAL = 1;
   localparam int ST_FS_HIGH = 2;
   localparam int ST_ALT_REQUEST = 3;
   localparam int ST_CALIBRATION = 4;
   localparam int ST_CLOCK_RESET = 5;
   localparam int ST_FS_FROM_REG = 6;
   localparam int ST_WIDTH = 7;

   // ************************************************************
   // Values after reset
   // ************************************************************
   localparam logic [FSADJ_W-1:0] FSADJ_RESET = 8'h80;
   localparam logic [DATA_W-1:0] READ_IDLE = 16'h0000;
   localparam logic [COUNT_W-1:0] COUNT_RESET = 8'h00;
   // Pin-controlled, single-ended reset, mid-level shared pin
   localparam logic [4:0] PIN_SYNC_RESET = 5'h03;
   localparam logic STATUS_BIT_RESET = 1'h0;
   localparam logic FS_HIGH_RESET = 1'h1;

   // ************************************************************
   // Types
   // ************************************************************
   typedef enum logic [1:0] {
      LEVEL_LOW,
      LEVEL_MID,
      LEVEL_HIGH
   } csd_level_t;

   typedef enum logic [1:0] {
      MODE_PIN_SE,
      MODE_PIN_DIFF,
      MODE_EXT_SE,
      MODE_EXT_DIFF
   } csd_mode_t;

   // Pin-mode range from the shared pin; mid-level keeps the high range
   function automatic logic fs_high_from_level(input csd_level_t level);
      return (level != LEVEL_LOW);
   endfunction

endpackage

// File: src/csd_reg_if.sv
// Carrier between the strap decoder core and its register file
`timescale 1ns/100ps
interface csd_reg_if;
   logic [csd_pkg::ADDR_W-1:0] addr;
   logic [csd_pkg::DATA_W-1:0] wdata;
   logic write;
   logic read;
   logic write_allowed;
   logic [csd_pkg::ST_WIDTH-1:0] status;
   logic [csd_pkg::COUNT_W-1:0] mode_changes;
   logic [csd_pkg::DATA_W-1:0] rdata;
   logic [csd_pkg::FSADJ_W-1:0] fsadj_i;
   logic [csd_pkg::FSADJ_W-1:0] fsadj_q;

   modport core (
      output addr, wdata, write, read, write_allowed, status, mode_changes,
      input rdata, fsadj_i, fsadj_q
   );
   modport regs (
      input addr, wdata, write, read, write_allowed, status, mode_changes,
      output rdata, fsadj_i, fsadj_q
   );
endinterface

// File: src/csd_sync.sv
// Three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/100ps
module csd_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RESET_VAL = '0
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // Pins and filtered levels
   input wire logic [W-1:0] pin_in,
   output logic [W-1:0] level_out
);
   logic [W-1:0] stage1_reg;
   logic [W-1:0] stage2_reg;
   logic [W-1:0] stage3_reg;
   logic [W-1:0] level_reg;
   logic [W-1:0] disagree;
   logic [W-1:0] level_next;

   // Only stages two and three are compared; stage one may be metastable
   assign disagree = stage2_reg ^ stage3_reg;
   assign level_next = (stage3_reg & ~disagree) | (level_reg & disagree);
   assign level_out = level_reg;

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         stage1_reg <= RESET_VAL;
         stage2_reg <= RESET_VAL;
         stage3_reg <= RESET_VAL;
         level_reg <= RESET_VAL;
      end else begin
         stage1_reg <= pin_in;
         stage2_reg <= stage1_reg;
         stage3_reg <= stage2_reg;
         level_reg <= level_next;
      end
   end
endmodule

// File: src/csd_regs.sv
// Register file: full-scale adjust words, status and mode change count
`timescale 1ns/100ps
module csd_regs (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // Core side
   csd_reg_if.regs bus
);
   logic [csd_pkg::FSADJ_W-1:0] fsadj_i_reg;
   logic [csd_pkg::FSADJ_W-1:0] fsadj_q_reg;
   logic [csd_pkg::DATA_W-1:0] rdata_reg;
   logic [csd_pkg::DATA_W-1:0] rdata_next;
   logic hit_i;
   logic hit_q;
   logic write_i;
   logic write_q;

   assign hit_i = (bus.addr == csd_pkg::ADDR_FSADJ_I);
   assign hit_q = (bus.addr == csd_pkg::ADDR_FSADJ_Q);
   // Writes outside extended mode are dropped silently
   assign write_i = bus.write & bus.write_allowed & hit_i; // see RL8
   assign write_q = bus.write & bus.write_allowed & hit_q; // see RL8

   assign rdata_next = !bus.read ? csd_pkg::READ_IDLE :
      (bus.addr == csd_pkg::ADDR_STATUS) ?
         {{(csd_pkg::DATA_W - csd_pkg::ST_WIDTH){1'b0}}, bus.status} :
      hit_i ? {{(csd_pkg::DATA_W - csd_pkg::FSADJ_W){1'b0}}, fsadj_i_reg} :
      hit_q ? {{(csd_pkg::DATA_W - csd_pkg::FSADJ_W){1'b0}}, fsadj_q_reg} :
      (bus.addr == csd_pkg::ADDR_MODE_CHANGES) ?
         {{(csd_pkg::DATA_W - csd_pkg::COUNT_W){1'b0}}, bus.mode_changes} :
      csd_pkg::READ_IDLE;

   assign bus.rdata = rdata_reg;
   assign bus.fsadj_i = fsadj_i_reg;
   assign bus.fsadj_q = fsadj_q_reg;

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         fsadj_i_reg <= csd_pkg::FSADJ_RESET;
         fsadj_q_reg <= csd_pkg::FSADJ_RESET;
         rdata_reg <= csd_pkg::READ_IDLE;
      end else begin
         rdata_reg <= rdata_next;
         if (write_i) begin
            fsadj_i_reg <= bus.wdata[csd_pkg::FSADJ_W-1:0];
         end
         if (write_q) begin
            fsadj_q_reg <= bus.wdata[csd_pkg::FSADJ_W-1:0];
         end
      end
   end
endmodule

// File: src/csd_top.sv
// Control mode strap decoder: strap pin decode, mode selection and reset receiver
//
// Behaviour
// RL1: Calibration flag output is high exactly while internal calibration runs.
// RL2: Dedicated select high disables extended control; only control pins configure.
// RL3: Dedicated select low enables extended control through serial registers.
// RL4: Dedicated select overrides any extended request from the shared pin.
// RL5: Reset-style high or floating: single-ended reset, shared pin is range/enable.
// RL6: Reset-style low: differential reset, shared pin is the negative half.
// RL7: Differential reset mode ignores pin range and defaults to high range.
// RL8: Full-scale adjust registers writable only while dedicated select is low.
// RL9: Board grounds common mode output for AC coupling, otherwise DC coupling.
// RL10: Single-ended pin mode: shared pin low gives reduced range, high gives high.
// RL11: Single-ended mode: shared pin mid-level requests extended control.
// RL12: Strap inputs are synchronised before decode; outputs change on a clock edge.
`timescale 1ns/100ps
module csd_top (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_in,

   // Strap and reset pins
   input wire logic extended_control_select_in,
   input wire logic reset_style_select_in,
   input wire logic shared_pin_above_in,
   input wire logic shared_pin_below_in,
   input wire logic output_clock_reset_pos_in,

   // Internal calibration engine
   input wire logic calibration_running_in,

   // Register port
   input wire logic [csd_pkg::ADDR_W-1:0] reg_addr_in,
   input wire logic [csd_pkg::DATA_W-1:0] reg_wdata_in,
   input wire logic reg_write_in,
   input wire logic reg_read_in,
   output logic [csd_pkg::DATA_W-1:0] reg_rdata_out,

   // Decoded control fields
   output logic calibration_active_flag_out,
   output logic extended_mode_out,
   output logic differential_reset_out,
   output logic alternate_extended_enable_out,
   output logic full_scale_range_select_out,
   output logic full_scale_from_register_out,
   output logic [csd_pkg::FSADJ_W-1:0] full_scale_adjust_i_out,
   output logic [csd_pkg::FSADJ_W-1:0] full_scale_adjust_q_out,
   output logic output_clock_reset_out
);

   // ************************************************************
   // Pin synchronisers
   // ************************************************************
   logic [4:0] pins_raw;
   logic [4:0] pins_sync;
   logic ece_level;
   logic style_level;
   logic above_level;
   logic below_level;
   logic reset_pos_level;

   // All straps share one synchroniser so a mode change lands on one edge
   assign pins_raw = {
      output_clock_reset_pos_in,
      shared_pin_below_in,
      shared_pin_above_in,
      reset_style_select_in,
      extended_control_select_in
   };

   // Reset levels read as pin mode with single-ended reset, as after power-up
   csd_sync #(
      .W(5),
      .RESET_VAL(csd_pkg::PIN_SYNC_RESET)
   ) u_pin_sync (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .pin_in(pins_raw),
      .level_out(pins_sync)
   ); // see RL12

   assign ece_level = pins_sync[0];
   assign style_level = pins_sync[1];
   assign above_level = pins_sync[2];
   assign below_level = pins_sync[3];
   assign reset_pos_level = pins_sync[4];

   // ************************************************************
   // Shared pin level decode
   // ************************************************************
   // Level is registered so an illegal comparator pair never glitches the decode
   csd_pkg::csd_level_t level_reg;
   csd_pkg::csd_level_t level_next;

   // Both comparators high is impossible on a sound pin; hold the last level
   assign level_next = (above_level && !below_level) ? csd_pkg::LEVEL_HIGH :
      (below_level && !above_level) ? csd_pkg::LEVEL_LOW :
      (!above_level && !below_level) ? csd_pkg::LEVEL_MID :
      level_reg;

   // ************************************************************
   // Mode selection
   // ************************************************************
   logic single_ended;
   logic extended_next;
   logic alt_request_next;
   csd_pkg::csd_mode_t mode_reg;
   csd_pkg::csd_mode_t mode_next;

   // Floating reset-style pin is pulled high and reads as single-ended
   assign single_ended = style_level; // see RL5
   // The shared pin request is only reported; the dedicated pin decides
   assign alt_request_next = single_ended && (level_next == csd_pkg::LEVEL_MID); // see RL11
   assign extended_next = !ece_level; // see RL2 RL3 RL4

   assign mode_next = extended_next ?
      (single_ended ? csd_pkg::MODE_EXT_SE : csd_pkg::MODE_EXT_DIFF) :
      (single_ended ? csd_pkg::MODE_PIN_SE : csd_pkg::MODE_PIN_DIFF); // see RL6

   // ************************************************************
   // Full-scale range and source
   // ************************************************************
   logic mode_extended;
   logic mode_differential;
   logic fs_high_next;

   always_comb begin
      mode_extended = 1'b0;
      mode_differential = 1'b0;
      unique case (mode_next)
         csd_pkg::MODE_PIN_SE: begin
            mode_extended = 1'b0;
            mode_differential = 1'b0;
         end
         csd_pkg::MODE_PIN_DIFF: begin
            mode_extended = 1'b0;
            mode_differential = 1'b1;
         end
         csd_pkg::MODE_EXT_SE: begin
            mode_extended = 1'b1;
            mode_differential = 1'b0;
         end
         csd_pkg::MODE_EXT_DIFF: begin
            mode_extended = 1'b1;
            mode_differential = 1'b1;
         end
      endcase
   end

   // Differential mode owns the shared pin, so the range falls back to high
   assign fs_high_next = mode_differential ? csd_pkg::FS_HIGH_RESET :
      csd_pkg::fs_high_from_level(level_next); // see RL7 RL10

   // ************************************************************
   // Output clock reset receiver
   // ************************************************************
   logic clock_reset_next;
   logic diff_assert;
   logic diff_release;

   // Differential pair: pos high with neg low asserts, the reverse releases;
   // equal halves are not a valid differential state and keep the last value
   assign diff_assert = reset_pos_level && (level_next == csd_pkg::LEVEL_LOW);
   assign diff_release = !reset_pos_level && (level_next == csd_pkg::LEVEL_HIGH);
   assign clock_reset_next = !mode_differential ? reset_pos_level :
      diff_assert ? 1'b1 :
      diff_release ? 1'b0 :
      output_clock_reset_out; // see RL6

   // ************************************************************
   // Mode change counter
   // ************************************************************
   logic [csd_pkg::COUNT_W-1:0] mode_changes_reg;
   logic [csd_pkg::COUNT_W-1:0] mode_changes_next;

   // Wraps at full count; software compares two reads for activity
   assign mode_changes_next = (mode_next != mode_reg) ?
      mode_changes_reg + 8'h01 : mode_changes_reg;

   // ************************************************************
   // Register file
   // ************************************************************
   csd_reg_if reg_bus ();

   assign reg_bus.addr = reg_addr_in;
   assign reg_bus.wdata = reg_wdata_in;
   assign reg_bus.write = reg_write_in;
   assign reg_bus.read = reg_read_in;
   assign reg_bus.write_allowed = extended_mode_out; // see RL8
   assign reg_bus.mode_changes = mode_changes_reg;
   assign reg_bus.status = {
      full_scale_from_register_out,
      output_clock_reset_out,
      calibration_active_flag_out,
      alternate_extended_enable_out,
      full_scale_range_select_out,
      differential_reset_out,
      extended_mode_out
   };

   csd_regs u_regs (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .bus(reg_bus.regs)
   );

   assign reg_rdata_out = reg_bus.rdata;
   assign full_scale_adjust_i_out = reg_bus.fsadj_i;
   assign full_scale_adjust_q_out = reg_bus.fsadj_q;

   // ************************************************************
   // State registers
   // ************************************************************
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         level_reg <= csd_pkg::LEVEL_MID;
      end else begin
         level_reg <= level_next;
      end
   end

   // Kept only to spot mode changes for the counter
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         mode_reg <= csd_pkg::MODE_PIN_SE;
      end else begin
         mode_reg <= mode_next;
      end
   end

   // Counts every settled change, returns to an earlier mode included
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         mode_changes_reg <= csd_pkg::COUNT_RESET;
      end else begin
         mode_changes_reg <= mode_changes_next;
      end
   end

   // ************************************************************
   // Output registers
   // ************************************************************
   // One register per output keeps each block short and every output glitch-free
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         extended_mode_out <= csd_pkg::STATUS_BIT_RESET;
      end else begin
         extended_mode_out <= mode_extended; // see RL2 RL3
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         differential_reset_out <= csd_pkg::STATUS_BIT_RESET;
      end else begin
         differential_reset_out <= mode_differential; // see RL5 RL6
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         alternate_extended_enable_out <= csd_pkg::STATUS_BIT_RESET;
      end else begin
         alternate_extended_enable_out <= alt_request_next; // see RL11
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         full_scale_from_register_out <= csd_pkg::STATUS_BIT_RESET;
      end else begin
         full_scale_from_register_out <= mode_extended; // see RL3
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         full_scale_range_select_out <= csd_pkg::FS_HIGH_RESET;
      end else begin
         full_scale_range_select_out <= fs_high_next; // see RL7 RL10
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         output_clock_reset_out <= csd_pkg::STATUS_BIT_RESET;
      end else begin
         output_clock_reset_out <= clock_reset_next;
      end
   end

   // Calibration engine shares this clock, so no synchroniser is needed
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         calibration_active_flag_out <= csd_pkg::STATUS_BIT_RESET;
      end else begin
         calibration_active_flag_out <= calibration_running_in; // see RL1
      end
   end

endmodule

// File: verification/csd_strap_model.sv
// Board strap model: turns requested strap settings into mode pin levels
`timescale 1ns/100ps
module csd_strap_model (
   // Requested settings
   input wire logic ext_sel_in,
   input wire logic style_sel_in,
   input wire csd_pkg::csd_level_t level_in,
   // Pins towards the device
   output logic extended_control_select_out,
   output logic reset_style_select_out,
   output logic shared_pin_above_out,
   output logic shared_pin_below_out,
   output logic common_mode_grounded_out
);
   // Inputs are DC coupled on this board, so the common mode pin is left free
   assign common_mode_grounded_out = 1'b0;
   assign extended_control_select_out = ext_sel_in;
   assign reset_style_select_out = style_sel_in;
   // One comparator at a time; mid level leaves both low
   assign shared_pin_above_out = (level_in == csd_pkg::LEVEL_HIGH);
   assign shared_pin_below_out = (level_in == csd_pkg::LEVEL_LOW);
endmodule

// File: verification/csd_top_asserts.sv
// Concurrent checks on the strap decoder top ports
`timescale 1ns/100ps
module csd_top_asserts (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // Pins and calibration
   input wire logic extended_control_select_in,
   input wire logic reset_style_select_in,
   input wire logic shared_pin_above_in,
   input wire logic shared_pin_below_in,
   input wire logic output_clock_reset_pos_in,
   input wire logic calibration_running_in,
   // Register port
   input wire logic [csd_pkg::ADDR_W-1:0] reg_addr_in,
   input wire logic [csd_pkg::DATA_W-1:0] reg_wdata_in,
   input wire logic reg_write_in,
   input wire logic reg_read_in,
   input wire logic [csd_pkg::DATA_W-1:0] reg_rdata_out,
   // Decoded fields
   input wire logic calibration_active_flag_out,
   input wire logic extended_mode_out,
   input wire logic differential_reset_out,
   input wire logic alternate_extended_enable_out,
   input wire logic full_scale_range_select_out,
   input wire logic full_scale_from_register_out,
   input wire logic [csd_pkg::FSADJ_W-1:0] full_scale_adjust_i_out,
   input wire logic [csd_pkg::FSADJ_W-1:0] full_scale_adjust_q_out,
   input wire logic output_clock_reset_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);
   // Pin settings must hold 7 cycles so the synchronisers have settled
   wire se_low = reset_style_select_in && shared_pin_below_in && !shared_pin_above_in;
   wire se_mid = reset_style_select_in && !shared_pin_below_in && !shared_pin_above_in;
   wire adj_wr = reg_write_in && reg_addr_in == csd_pkg::ADDR_FSADJ_I;
   a_cal_follow: assert property (
      $past(!rst_in) |-> calibration_active_flag_out == $past(calibration_running_in))
      else $error("calibration flag does not follow");
   a_pin_only: assert property (
      extended_control_select_in [*7] |-> !extended_mode_out && !full_scale_from_register_out)
      else $error("extended mode while select high");
   a_ext_mode: assert property (
      (!extended_control_select_in) [*7] |-> extended_mode_out && full_scale_from_register_out)
      else $error("extended mode missing");
   a_diff_mode: assert property (
      (!reset_style_select_in) [*7] |-> differential_reset_out && !alternate_extended_enable_out)
      else $error("differential mode missing");
   a_fs_default: assert property (
      differential_reset_out |-> full_scale_range_select_out)
      else $error("reduced range in differential mode");
   a_fs_reduced: assert property (
      se_low [*7] |-> !full_scale_range_select_out)
      else $error("range not reduced");
   a_alt_request: assert property (
      se_mid [*7] |-> alternate_extended_enable_out && !differential_reset_out)
      else $error("alternate request missing");
   a_se_clk_reset: assert property (
      (reset_style_select_in && output_clock_reset_pos_in) [*7] |-> output_clock_reset_out)
      else $error("single-ended reset not passed");
   a_adj_locked: assert property (
      adj_wr && !extended_mode_out |=> $stable(full_scale_adjust_i_out))
      else $error("adjust word written in pin mode");
   a_adj_write: assert property (
      adj_wr && extended_mode_out |=> full_scale_adjust_i_out == $past(reg_wdata_in[7:0]))
      else $error("adjust word not written");
   a_read_idle: assert property (
      !$past(reg_read_in) |-> reg_rdata_out == csd_pkg::READ_IDLE)
      else $error("read data outside read cycle");
   c_ext_diff: cover property (extended_mode_out && differential_reset_out);
   c_adj_write: cover property (adj_wr && extended_mode_out);
   c_cal: cover property ($rose(calibration_active_flag_out));
endmodule

bind csd_top csd_top_asserts u_asserts (.*);

// File: verification/csd_top_tb_top.sv
// Self-checking bench for the control mode strap decoder
`timescale 1ns/100ps
module csd_top_tb_top;
   logic clk_in;
   logic rst_in;
   logic ext_sel, style_sel, pos, cal, re_d, clk_exp;
   csd_pkg::csd_level_t level;
   logic ece_p, style_p, above_p, below_p;
   logic [csd_pkg::ADDR_W-1:0] addr;
   logic [csd_pkg::DATA_W-1:0] wdata, rdata, w1, w2;
   logic we, re, ext_o, diff_o, alt_o, fs_o, fsreg_o, cal_o, clkrst_o;
   logic [7:0] adj_i, adj_q, cnt_exp;
   logic [1:0] mode_prev;
   logic [15:0] exp_q[$];
   int n_fail, total_checks;
   wire [15:0] outs_now = {9'h000, fsreg_o, clkrst_o, cal_o, alt_o, fs_o, diff_o, ext_o};

   csd_strap_model u_board (.ext_sel_in(ext_sel), .style_sel_in(style_sel), .level_in(level),
      .extended_control_select_out(ece_p), .reset_style_select_out(style_p),
      .shared_pin_above_out(above_p), .shared_pin_below_out(below_p),
      .common_mode_grounded_out());
   csd_top u_dut (.clk_in(clk_in), .rst_in(rst_in), .extended_control_select_in(ece_p),
      .reset_style_select_in(style_p), .shared_pin_above_in(above_p),
      .shared_pin_below_in(below_p), .output_clock_reset_pos_in(pos),
      .calibration_running_in(cal), .reg_addr_in(addr), .reg_wdata_in(wdata),
      .reg_write_in(we), .reg_read_in(re), .reg_rdata_out(rdata),
      .calibration_active_flag_out(cal_o), .extended_mode_out(ext_o),
      .differential_reset_out(diff_o), .alternate_extended_enable_out(alt_o),
      .full_scale_range_select_out(fs_o), .full_scale_from_register_out(fsreg_o),
      .full_scale_adjust_i_out(adj_i), .full_scale_adjust_q_out(adj_q),
      .output_clock_reset_out(clkrst_o));

   // ******************************
   // Bus tasks and scoreboard
   // ******************************
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      addr <= a;
      wdata <= d;
      we <= 1'b1;
      re <= 1'b0;
      @(posedge clk_in);
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] e);
      addr <= a;
      we <= 1'b0;
      re <= 1'b1;
      exp_q.push_back(e);
      @(posedge clk_in);
   endtask
   task automatic idle(input int n);
      we <= 1'b0;
      re <= 1'b0;
      repeat (n) @(posedge clk_in);
   endtask
   task automatic cmp(input string name, input logic [15:0] e, input logic [15:0] g);
      total_checks++;
      if (g !== e) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", name, e, g);
      end
   endtask
   task automatic wrap_up();
      if (n_fail == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   function automatic logic [15:0] st_exp(input logic e, s, c, k, input int l);
      logic [15:0] v;
      v = 16'h0000;
      v[csd_pkg::ST_EXTENDED] = !e;
      v[csd_pkg::ST_DIFFERENTIAL] = !s;
      v[csd_pkg::ST_FS_HIGH] = !s || l != 0;
      v[csd_pkg::ST_ALT_REQUEST] = s && l == 1;
      v[csd_pkg::ST_CALIBRATION] = c;
      v[csd_pkg::ST_CLOCK_RESET] = k;
      v[csd_pkg::ST_FS_FROM_REG] = !e;
      return v;
   endfunction

   // Read data stands only in the cycle after the strobe
   always @(posedge clk_in) begin
      if (re_d === 1'b1)
         cmp("read data", exp_q.size() > 0 ? exp_q.pop_front() : 16'hffff, rdata);
      re_d <= re;
   end

   initial begin
      clk_in = 1'b0;
      forever #2 clk_in = ~clk_in;
   end
   initial begin
      repeat (5000) @(posedge clk_in);
      n_fail++;
      wrap_up();
   end

   // ******************************
   // Main sequence
   // ******************************
   initial begin
      logic p, c;
      rst_in = 1'b1;
      {addr, wdata, we, re, re_d, pos, cal, clk_exp, mode_prev, cnt_exp} = '0;
      {ext_sel, style_sel} = 2'b11;
      level = csd_pkg::LEVEL_MID;
      n_fail = 0;
      total_checks = 0;
      void'($urandom(77117));
      repeat (12) @(posedge clk_in);
      rst_in <= 1'b0;
      @(posedge clk_in);
      rd(csd_pkg::ADDR_FSADJ_I, {8'h00, csd_pkg::FSADJ_RESET});
      rd(csd_pkg::ADDR_FSADJ_Q, {8'h00, csd_pkg::FSADJ_RESET});
      rd(csd_pkg::ADDR_MODE_CHANGES, 16'h0000);
      rd(4'hf, csd_pkg::READ_IDLE);
      idle(8);
      rd(csd_pkg::ADDR_STATUS, st_exp(1, 1, 0, 0, 1));
      for (int e = 0; e < 2; e++) begin
         for (int s = 0; s < 2; s++) begin
            for (int l = 0; l < 3; l++) begin
               p = 1'($urandom);
               c = 1'($urandom);
               ext_sel <= e[0];
               style_sel <= s[0];
               level <= csd_pkg::csd_level_t'(l[1:0]);
               pos <= p;
               cal <= c;
               idle(8);
               // Differential mode holds the reset on a mid-level negative half
               if (s != 0)
                  clk_exp = p;
               else if (p && l == 0)
                  clk_exp = 1'b1;
               else if (!p && l == 2)
                  clk_exp = 1'b0;
               if (mode_prev != {!e[0], !s[0]})
                  cnt_exp++;
               mode_prev = {!e[0], !s[0]};
               cmp("outputs", st_exp(e[0], s[0], c, clk_exp, l), outs_now);
               rd(csd_pkg::ADDR_STATUS, st_exp(e[0], s[0], c, clk_exp, l));
            end
         end
      end
      w1 = 16'($urandom);
      w2 = 16'($urandom);
      wr(csd_pkg::ADDR_FSADJ_I, w1);
      rd(csd_pkg::ADDR_FSADJ_I, {8'h00, csd_pkg::FSADJ_RESET});
      cmp("adjust i", {8'h00, csd_pkg::FSADJ_RESET}, {8'h00, adj_i});
      ext_sel <= 1'b0;
      cnt_exp++;
      idle(8);
      wr(csd_pkg::ADDR_FSADJ_I, w1);
      wr(csd_pkg::ADDR_FSADJ_Q, w2);
      wr(4'hf, ~w1);
      rd(csd_pkg::ADDR_FSADJ_I, {8'h00, w1[7:0]});
      rd(csd_pkg::ADDR_FSADJ_Q, {8'h00, w2[7:0]});
      cmp("adjust i", {8'h00, w1[7:0]}, {8'h00, adj_i});
      cmp("adjust q", {8'h00, w2[7:0]}, {8'h00, adj_q});
      rd(4'hf, csd_pkg::READ_IDLE);
      rd(csd_pkg::ADDR_MODE_CHANGES, {8'h00, cnt_exp});
      idle(3);
      wrap_up();
   end
endmodule
